// file: verilog/t3pwm_top.sv
// Top of the eight-bit period and PWM timer with its APB register file.
`timescale 1ns/100ps
module t3pwm_top (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [11:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire t3pwm_pkg::t3pwm_src_t src_i,
	output logic [2:0] timer_pin_o,
	output logic [2:0] timer_pin_sel_o
);
	import t3pwm_pkg::*;

	function automatic logic hit(input logic [11:0] addr,
			input logic [7:0] idx);
		hit = (addr[1:0] == 2'b00) && (addr[11:2] == {2'b00, idx});
	endfunction

	// Register file.
	logic [7:0] bound_ff;
	t3pwm_ctrl_t ctrl_ff;
	t3pwm_div_t div_ff;
	logic [7:0] count_ff;
	logic period_lvl_ff;
	logic pwm_lvl_ff;
	logic [2:0] pin_ff;
	logic [2:0] pin_sel_ff;
	logic [31:0] rdata_ff;

	// Bus decode.
	wire hit_bound = hit(paddr_i, IDX_BOUND);
	wire hit_ctrl = hit(paddr_i, IDX_CTRL);
	wire hit_count = hit(paddr_i, IDX_COUNT);
	wire hit_div = hit(paddr_i, IDX_DIV);
	wire hit_status = hit(paddr_i, IDX_STATUS);
	wire mapped = hit_bound | hit_ctrl | hit_count | hit_div | hit_status;
	wire access = psel_i && penable_i;
	wire setup = psel_i && !penable_i;
	// Writes land only on byte lane 0; the upper lanes hold nothing.
	wire wr_en = access && pwrite_i && pstrb_i[0];
	wire wr_bound = wr_en && hit_bound;
	wire wr_ctrl = wr_en && hit_ctrl;
	wire wr_count = wr_en && hit_count;
	wire wr_div = wr_en && hit_div;
	// The status register is read only, so a write to it is an error too.
	wire bad = !mapped || (pwrite_i && hit_status);

	assign pready_o = 1'b1;
	assign pslverr_o = access && bad;
	assign prdata_o = rdata_ff;

	// Timer tick chain.
	logic src_tick;
	logic tick;

	t3pwm_clk_src u_clk_src (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.src_i(src_i),
		.clk_sel_i(ctrl_ff.clk_sel),
		.tick_o(src_tick)
	);

	t3pwm_divider u_divider (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.tick_i(src_tick),
		.presc_i(div_ff.presc),
		.scalar_i(div_ff.scalar),
		.tick_o(tick)
	);

	// Counter and waveform.
	wire running = (ctrl_ff.clk_sel != 4'b0000);
	wire [7:0] mask = div_ff.res6 ? MASK_6BIT : MASK_8BIT;
	wire [7:0] cnt_m = count_ff & mask;
	wire [7:0] bnd_m = bound_ff & mask;
	wire pwm_wrap = (cnt_m == mask);
	wire per_match = (count_ff == bound_ff);
	wire [7:0] cnt_inc = count_ff + 8'h01;
	wire [7:0] nxt_count_pwm = pwm_wrap ? 8'h00 : (cnt_inc & mask);
	wire [7:0] nxt_count_per = per_match ? 8'h00 : cnt_inc;
	wire [7:0] nxt_count = ctrl_ff.pwm_mode ? nxt_count_pwm : nxt_count_per;
	wire nxt_pwm_lvl = (cnt_m < bnd_m);
	wire raw_lvl = ctrl_ff.pwm_mode ? pwm_lvl_ff : period_lvl_ff;
	wire out_lvl = raw_lvl ^ ctrl_ff.invert;

	// Pin routing: code 00 selects no pin, so every pin is driven low.
	logic [2:0] nxt_pin_sel;
	always_comb begin
		case (ctrl_ff.out_sel)
			2'b01: nxt_pin_sel = 3'b001;
			2'b10: nxt_pin_sel = 3'b010;
			2'b11: nxt_pin_sel = 3'b100;
			default: nxt_pin_sel = 3'b000;
		endcase
	end
	wire [2:0] nxt_pin = nxt_pin_sel & {3{out_lvl}};

	// Status is built from state only; the count itself is never readable.
	wire [7:0] status = {6'h00, running, out_lvl};
	logic [7:0] nxt_rdata;
	always_comb begin
		if (hit_ctrl) begin
			nxt_rdata = ctrl_ff;
		end else if (hit_status) begin
			nxt_rdata = status;
		end else begin
			nxt_rdata = 8'h00;
		end
	end

	// Register writes.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			bound_ff <= RST_BOUND;
			ctrl_ff <= RST_CTRL;
			div_ff <= RST_DIV;
		end else begin
			if (wr_bound) begin
				bound_ff <= pwdata_i[7:0];
			end
			if (wr_ctrl) begin
				ctrl_ff <= pwdata_i[7:0];
			end
			if (wr_div) begin
				div_ff <= pwdata_i[7:0];
			end
		end
	end

	// A count write wins over a tick in the same cycle so software sees it.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			count_ff <= RST_COUNT;
		end else if (wr_count) begin
			count_ff <= pwdata_i[7:0];
		end else if (tick) begin
			count_ff <= nxt_count;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			period_lvl_ff <= 1'b0;
			pwm_lvl_ff <= 1'b0;
		end else begin
			if (tick && !ctrl_ff.pwm_mode && per_match) begin
				period_lvl_ff <= !period_lvl_ff;
			end
			pwm_lvl_ff <= nxt_pwm_lvl;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pin_ff <= 3'b000;
			pin_sel_ff <= 3'b000;
		end else begin
			pin_ff <= nxt_pin;
			pin_sel_ff <= nxt_pin_sel;
		end
	end

	// Read data is captured in the setup phase and stands in the access phase.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_ff <= 32'h0000_0000;
		end else if (setup) begin
			rdata_ff <= {24'h00_0000, nxt_rdata};
		end
	end

	assign timer_pin_o = pin_ff;
	assign timer_pin_sel_o = pin_sel_ff;

endmodule // t3pwm_top

// file: pkg/t3pwm_pkg.sv
// Package with register map, field layouts and clock codes of the timer.
package t3pwm_pkg;

	// Register indices; the APB byte address is four times the index.
	localparam logic [7:0] IDX_BOUND = 8'h23;
	localparam logic [7:0] IDX_CTRL = 8'h2e;
	localparam logic [7:0] IDX_COUNT = 8'h2f;
	localparam logic [7:0] IDX_DIV = 8'h39;
	localparam logic [7:0] IDX_STATUS = 8'h3a;

	// Field positions of timer_control_setup.
	localparam int CTRL_CLK_LSB = 4;
	localparam int CTRL_OUT_LSB = 2;
	localparam int CTRL_MODE_BIT = 1;
	localparam int CTRL_INV_BIT = 0;

	// Field positions of timer_divider_setup.
	localparam int DIV_RES_BIT = 7;
	localparam int DIV_PRE_LSB = 5;
	localparam int DIV_SCL_LSB = 0;

	// Reset values.
	localparam logic [7:0] RST_BOUND = 8'h00;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_DIV = 8'h00;

	// Counter wrap masks for the two PWM resolutions.
	localparam logic [7:0] MASK_8BIT = 8'hff;
	localparam logic [7:0] MASK_6BIT = 8'h3f;

	// Prescaler terminal counts for divide by 1, 4, 16 and 64.
	localparam logic [5:0] PRE_LIM_1 = 6'h00;
	localparam logic [5:0] PRE_LIM_4 = 6'h03;
	localparam logic [5:0] PRE_LIM_16 = 6'h0f;
	localparam logic [5:0] PRE_LIM_64 = 6'h3f;

	// Clock source codes.
	typedef enum logic [3:0] {
		T3PWM_CLK_OFF = 4'b0000,
		T3PWM_CLK_SYS = 4'b0001,
		T3PWM_CLK_FAST = 4'b0010,
		T3PWM_CLK_SLOW = 4'b0100,
		T3PWM_CLK_P0R = 4'b1000,
		T3PWM_CLK_P0F = 4'b1001,
		T3PWM_CLK_P1R = 4'b1010,
		T3PWM_CLK_P1F = 4'b1011,
		T3PWM_CLK_P2R = 4'b1100,
		T3PWM_CLK_P2F = 4'b1101
	} t3pwm_clk_t;

	typedef struct packed {
		logic [3:0] clk_sel;
		logic [1:0] out_sel;
		logic pwm_mode;
		logic invert;
	} t3pwm_ctrl_t;

	typedef struct packed {
		logic res6;
		logic [1:0] presc;
		logic [4:0] scalar;
	} t3pwm_div_t;

	typedef struct packed {
		logic fast_osc;
		logic slow_osc;
		logic [2:0] ext_pin;
	} t3pwm_src_t;

endpackage

// file: verilog/t3pwm_clk_src.sv
// Clock source selection: synchronises the source pins and makes ticks.
`timescale 1ns/100ps
module t3pwm_clk_src (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire t3pwm_pkg::t3pwm_src_t src_i,
	input wire logic [3:0] clk_sel_i,
	output logic tick_o
);
	import t3pwm_pkg::*;

	logic [4:0] sync1_ff;
	logic [4:0] sync2_ff;
	logic [4:0] prev_ff;
	logic tick_ff;
	logic nxt_tick;
	wire [4:0] rise = sync2_ff & ~prev_ff;
	wire [4:0] fall = ~sync2_ff & prev_ff;

	// Only the second stage and its delayed copy feed the edge detectors.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_ff <= 5'h00;
			sync2_ff <= 5'h00;
			prev_ff <= 5'h00;
		end else begin
			sync1_ff <= src_i;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	// Reserved codes give no ticks, as the off code does, but the status still reports them as running.
	always_comb begin
		case (t3pwm_clk_t'(clk_sel_i))
			T3PWM_CLK_SYS: nxt_tick = 1'b1;
			T3PWM_CLK_FAST: nxt_tick = rise[4];
			T3PWM_CLK_SLOW: nxt_tick = rise[3];
			T3PWM_CLK_P0R: nxt_tick = rise[0];
			T3PWM_CLK_P0F: nxt_tick = fall[0];
			T3PWM_CLK_P1R: nxt_tick = rise[1];
			T3PWM_CLK_P1F: nxt_tick = fall[1];
			T3PWM_CLK_P2R: nxt_tick = rise[2];
			T3PWM_CLK_P2F: nxt_tick = fall[2];
			default: nxt_tick = 1'b0;
		endcase
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= nxt_tick;
		end
	end

	assign tick_o = tick_ff;

endmodule // t3pwm_clk_src

// file: verilog/t3pwm_divider.sv
// Two-stage clock divider: selectable prescaler followed by a five-bit scalar.
`timescale 1ns/100ps
module t3pwm_divider (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic [1:0] presc_i,
	input wire logic [4:0] scalar_i,
	output logic tick_o
);
	import t3pwm_pkg::*;

	logic [5:0] pre_cnt_ff;
	logic [4:0] scl_cnt_ff;
	logic tick_ff;
	logic [5:0] pre_lim;

	always_comb begin
		case (presc_i)
			2'b00: pre_lim = PRE_LIM_1;
			2'b01: pre_lim = PRE_LIM_4;
			2'b10: pre_lim = PRE_LIM_16;
			2'b11: pre_lim = PRE_LIM_64;
			default: pre_lim = PRE_LIM_1;
		endcase
	end

	// A shrinking setup may leave a count above the new limit; >= catches it.
	wire pre_end = tick_i && (pre_cnt_ff >= pre_lim);
	wire scl_end = pre_end && (scl_cnt_ff >= scalar_i);
	wire [5:0] nxt_pre_cnt = pre_end ? 6'h00 : pre_cnt_ff + 6'h01;
	wire [4:0] nxt_scl_cnt = scl_end ? 5'h00 : scl_cnt_ff + 5'h01;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pre_cnt_ff <= 6'h00;
			scl_cnt_ff <= 5'h00;
			tick_ff <= 1'b0;
		end else begin
			if (tick_i) begin
				pre_cnt_ff <= nxt_pre_cnt;
			end
			if (pre_end) begin
				scl_cnt_ff <= nxt_scl_cnt;
			end
			tick_ff <= scl_end;
		end
	end

	assign tick_o = tick_ff;

endmodule // t3pwm_divider

// file: test/t3pwm_monitor.sv
// Port assertions for the period and PWM timer.
`timescale 1ns/100ps
module t3pwm_monitor (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [11:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic [2:0] timer_pin_o,
	input wire logic [2:0] timer_pin_sel_o
);
	logic [7:0] ctl_ff;
	logic [3:0] idle_ff;
	wire acc = psel_i & penable_i;
	wire rd = acc & ~pwrite_i;
	wire wr = acc & pwrite_i & pstrb_i[0];
	wire ctl = paddr_i == 12'h0b8;
	wire wo = paddr_i == 12'h08c || paddr_i == 12'h0bc || paddr_i == 12'h0e4;
	wire [1:0] osel = ctl_ff[3:2];
	wire [2:0] sel_exp = osel == 2'h0 ? 3'h0 : 3'(3'h1 << (osel - 2'h1));
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			ctl_ff <= 8'h00;
		else if (wr && ctl)
			ctl_ff <= pwdata_i[7:0];
	end
	// A tick already in flight may still move the pins after a cut-off.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			idle_ff <= 4'h0;
		else if (wr || ctl_ff[7:4] != 4'h0)
			idle_ff <= 4'h0;
		else if (idle_ff != 4'hf)
			idle_ff <= idle_ff + 4'h1;
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	wo_read_a:
		assert property (rd && wo |-> prdata_o == 32'h0000_0000)
		else $error("write-only register read nonzero");
	ctl_read_a:
		assert property (rd && ctl |-> prdata_o == {24'h00_0000, ctl_ff})
		else $error("control readback wrong");
	bad_addr_a:
		assert property (acc && !(wo || ctl || paddr_i == 12'h0e8) |-> pslverr_o)
		else $error("unmapped access not flagged");
	good_addr_a:
		assert property (rd && (wo || ctl) |-> !pslverr_o)
		else $error("mapped read flagged");
	sel_onehot_a:
		assert property ($onehot0(timer_pin_sel_o))
		else $error("pin select not one-hot");
	pin_gate_a:
		assert property ((timer_pin_o & ~timer_pin_sel_o) == 3'h0)
		else $error("unselected pin driven");
	sel_map_a:
		assert property (wr && ctl |=> ##[0:1] timer_pin_sel_o == sel_exp)
		else $error("pin select does not follow control");
	off_hold_a:
		assert property (idle_ff > 4'h7 |-> $stable(timer_pin_o))
		else $error("pins move with timer disabled");
endmodule // t3pwm_monitor

bind t3pwm_top t3pwm_monitor u_t3pwm_monitor (.clock_i, .rst_i, .paddr_i,
	.psel_i, .penable_i, .pwrite_i, .pwdata_i, .pstrb_i, .prdata_o,
	.pready_o, .pslverr_o, .timer_pin_o, .timer_pin_sel_o);

// file: test/tb_top.sv
// Self-checking bench for the period and PWM timer.
`timescale 1ns/100ps
module tb_top;
	import t3pwm_pkg::*;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0000_0000;
	logic [3:0] pstrb_i = 4'hf;
	t3pwm_src_t src_i = '0;
	logic [31:0] prdata_o, rd;
	logic pready_o, pslverr_o, err;
	logic [2:0] timer_pin_o, timer_pin_sel_o;
	int mismatches = 0;
	int tests_run = 0;
	always #5 clock_i = ~clock_i;
	t3pwm_top u_t3pwm_top (.clock_i, .rst_i, .paddr_i, .psel_i, .penable_i,
		.pwrite_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
		.src_i, .timer_pin_o, .timer_pin_sel_o);
	task check(input string what, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= {24'h00_0000, d};
		@(posedge clock_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		if (pready_o !== 1'b1) begin
			mismatches++;
			report_and_stop;
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clock_i);
	endtask
	task idle(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task edges(input int pin, input int len, output int t);
		logic p;
		t = 0;
		p = timer_pin_o[pin];
		repeat (len) begin
			@(posedge clock_i);
			if (timer_pin_o[pin] !== p)
				t++;
			p = timer_pin_o[pin];
		end
	endtask
	task t_reset;
		check("pins", 32'({timer_pin_sel_o, timer_pin_o}), 32'h0000_0000);
		apb(1'b0, 12'h0b8, 8'h00);
		check("ctrl", rd, 32'h0000_0000);
		apb(1'b1, 12'h0bc, 8'ha5);
		apb(1'b0, 12'h0bc, 8'h00);
		check("count", rd, 32'h0000_0000);
		apb(1'b0, 12'h004, 8'h00);
		check("unmapped", 32'(err), 32'h0000_0001);
		apb(1'b1, 12'h0e8, 8'h00);
		check("status write", 32'(err), 32'h0000_0001);
		apb(1'b0, 12'h0e8, 8'h00);
		check("status", rd, 32'h0000_0000);
		// Lane 0 strobe low must leave the control register untouched.
		pstrb_i <= 4'he;
		apb(1'b1, 12'h0b8, 8'h14);
		pstrb_i <= 4'hf;
		apb(1'b0, 12'h0b8, 8'h00);
		check("strobe", rd, 32'h0000_0000);
		apb(1'b1, 12'h0bc, 8'h00);
		$display("t_reset done");
	endtask
	task automatic t_period;
		logic [7:0] dv[5] = '{8'h00, 8'h20, 8'h01, 8'h40, 8'h60};
		// Half period is three ticks times prescaler times scalar plus one.
		int hp[5] = '{3, 12, 6, 48, 192};
		int t;
		apb(1'b1, 12'h08c, 8'h02);
		apb(1'b1, 12'h0b8, 8'h14);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, 12'h0e4, dv[i]);
			idle(2 * hp[i]);
			edges(0, 6 * hp[i], t);
			check("period", 32'(t), 32'h0000_0006);
		end
		$display("t_period done");
	endtask
	task automatic t_pwm;
		logic [7:0] cv[5] = '{8'h16, 8'h17, 8'h16, 8'h1a, 8'h1e};
		logic [7:0] dv[5] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h80};
		logic [7:0] bv[5] = '{8'h40, 8'h40, 8'h00, 8'h08, 8'h50};
		int pv[5] = '{0, 0, 0, 1, 2};
		int hv[5] = '{64, 192, 0, 32, 64};
		int n;
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, 12'h0e4, dv[i]);
			apb(1'b1, 12'h08c, bv[i]);
			apb(1'b1, 12'h0b8, cv[i]);
			idle(300);
			n = 0;
			repeat (256) begin
				@(posedge clock_i);
				n += timer_pin_o[pv[i]];
			end
			check("high", 32'(n), 32'(hv[i]));
			check("sel", 32'(timer_pin_sel_o), 32'(1 << pv[i]));
		end
		$display("t_pwm done");
	endtask
	task automatic t_src;
		logic [7:0] cv[6] = '{8'h84, 8'h94, 8'h24, 8'h44, 8'ha4, 8'hc4};
		int bv[6] = '{0, 0, 4, 3, 1, 2};
		int t;
		int s;
		apb(1'b1, 12'h0b8, 8'h04);
		apb(1'b1, 12'h08c, 8'h00);
		apb(1'b1, 12'h0bc, 8'h00);
		idle(5);
		edges(0, 40, t);
		check("off", 32'(t), 32'h0000_0000);
		// Bound zero in period mode toggles the pin once per selected edge of the source.
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, 12'h0b8, cv[i]);
			apb(1'b0, 12'h0e8, 8'h00);
			check("running", rd & 32'h0000_0002, 32'h0000_0002);
			idle(10);
			s = 0;
			for (int j = 0; j < 4; j++) begin
				src_i[bv[i]] <= 1'b1;
				edges(0, 8, t);
				s += t;
				src_i[bv[i]] <= 1'b0;
				edges(0, 8, t);
				s += t;
			end
			edges(0, 8, t);
			check("src", 32'(s + t), 32'h0000_0004);
		end
		$display("t_src done");
	endtask
	initial begin
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		t_reset;
		t_period;
		t_pwm;
		t_src;
		report_and_stop;
	end
endmodule // tb_top
